/* sim/supply_pin_model.sv */
// Model of the supply monitor and the external reset pin circuitry.
// Assumes the bench commands it just after pclk rising edges.
`timescale 1ns/10ps
module supply_pin_model (
  // Clock.
  input wire logic pclk,
  // Commands from the bench.
  input wire logic por_req,
  input wire logic pin_req,
  input wire logic low_req,
  // Lines into the sequencer.
  output logic supply_por,
  output logic ext_reset_pin_n,
  output logic low_supply
);
  // Lines start idle; the pin rests high on its pull-up.
  initial begin
    supply_por = 1'b0;
    ext_reset_pin_n = 1'b1;
    low_supply = 1'b0;
  end
  // pin pulled low
  // Each line follows its command one edge later, like a slow monitor.
  always @(posedge pclk) begin
    supply_por <= por_req;
    ext_reset_pin_n <= ~pin_req;
    low_supply <= low_req;
  end
endmodule : supply_pin_model

/* sim/tb_reset_source_sequencer.sv */
// Self-checking bench for the reset source sequencer.
// Assumes the partner model drives the supply and pin lines.
`timescale 1ns/10ps
module tb_reset_source_sequencer;
  // Shortened release delay and register addresses.
  localparam int REL = 20;
  localparam logic [11:0] CFG = reset_seq_pkg::ADDR_CONFIG;
  localparam logic [11:0] CTL = reset_seq_pkg::ADDR_CTRL;
  localparam logic [31:0] DEF = 32'h0040088A;
  // Design and partner model inputs, all given a value at time zero.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic wdt_timeout = 1'b0;
  logic sleeping = 1'b0;
  logic por_req = 1'b0;
  logic pin_req = 1'b0;
  logic low_req = 1'b0;
  // Design outputs and the partner model's lines into the design.
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic supply_por;
  logic ext_reset_pin_n;
  logic low_supply;
  logic [2:0] low_supply_threshold;
  logic cpu_run;
  logic pc_clear;
  logic sp_clear;
  logic wake;
  logic [4:0] por_actions;
  logic timeout_flag;
  logic powerdown_flag;
  logic [7:0] second_control_reg;
  logic [7:0] timer0_control;
  logic [7:0] converter_control;
  // Bench bookkeeping.
  int miscompares = 0;
  int total_checks = 0;
  int n;
  logic [31:0] rd;
  logic err;

  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;

  reset_source_sequencer #(.RELEASE_CYCLES(REL)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_por(supply_por),
    .ext_reset_pin_n(ext_reset_pin_n), .low_supply(low_supply),
    .wdt_timeout(wdt_timeout), .sleeping(sleeping),
    .low_supply_threshold(low_supply_threshold), .cpu_run(cpu_run),
    .pc_clear(pc_clear), .sp_clear(sp_clear), .wake(wake),
    .por_actions(por_actions), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag),
    .second_control_reg(second_control_reg),
    .timer0_control(timer0_control),
    .converter_control(converter_control));

  supply_pin_model partner (
    .pclk(pclk), .por_req(por_req), .pin_req(pin_req),
    .low_req(low_req), .supply_por(supply_por),
    .ext_reset_pin_n(ext_reset_pin_n), .low_supply(low_supply));

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // Checks that a cycle count lies in a window.
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : in_range

  // Flags and core register defaults packed for comparison.
  function automatic logic [31:0] flags();
    return {30'h0, timeout_flag, powerdown_flag};
  endfunction : flags
  function automatic logic [31:0] ctl();
    return {8'h00, converter_control, timer0_control, second_control_reg};
  endfunction : ctl

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      miscompares++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits, bounded, for cpu_run (sel 0) or the wake pulse (sel 1).
  task automatic wait_hi(input int sel, output int cnt);
    cnt = 0;
    do begin
      @(negedge pclk);
      cnt++;
    end while ((sel == 0 ? cpu_run : wake) !== 1'b1 && cnt < 5000);
    if (cnt >= 5000) begin
      miscompares++;
      close_out();
    end
  endtask : wait_hi

  // One watchdog time-out pulse.
  task automatic wdt_pulse;
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    @(negedge pclk);
  endtask : wdt_pulse

  initial begin
    repeat (15) @(posedge pclk);
    check(flags(), 32'h0);
    check({27'h0, por_actions}, 32'h1F);
    check(ctl(), DEF);
    @(posedge pclk);
    presetn <= 1'b1;
    wait_hi(0, n);
    in_range(n, REL, REL + 3);
    check({27'h0, por_actions}, 32'h0);
    // Every threshold code reaches the supply monitor.
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, CFG, {28'h0, 3'(k), 1'b0});
      repeat (2) @(negedge pclk);
      check({29'h0, low_supply_threshold}, 32'(k));
    end
    // Configuration reads back what was last written.
    apb(1'b0, CFG, 32'h0);
    check(rd, 32'h0000000E);
    check({31'h0, err}, 32'h0);
    // An unmapped address is refused and reads as zero.
    apb(1'b0, 12'h00C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // A running watchdog reset behaves like a pin reset plus the flag.
    apb(1'b1, CTL, 32'h00A5C33C);
    wdt_pulse();
    check({31'h0, cpu_run}, 32'h0);
    check(flags(), 32'h2);
    check(ctl(), DEF);
    wait_hi(0, n);
    in_range(n, REL - 1, REL + 3);
    apb(1'b0, CTL, 32'h0);
    check(rd, DEF);
    // Sleeping wake: short and long start-up for RC, long for crystal.
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, CFG, k == 0 ? 32'h30 : (k == 1 ? 32'h10 : 32'h20));
      apb(1'b1, CTL, 32'h00123456);
      sleeping <= 1'b1;
      wdt_pulse();
      check({30'h0, sp_clear, pc_clear}, 32'h3);
      check(flags(), 32'h3);
      wait_hi(1, n);
      in_range(n, k == 0 ? 1 : 126, k == 0 ? 4 : 131);
      check(ctl(), 32'h00123456);
      @(posedge pclk);
      sleeping <= 1'b0;
      wait_hi(0, n);
    end
    // A pin reset keeps the flags and loads the defaults.
    @(posedge pclk);
    pin_req <= 1'b1;
    repeat (4) @(negedge pclk);
    check({30'h0, cpu_run, pc_clear}, 32'h1);
    check(flags(), 32'h3);
    check(ctl(), DEF);
    @(posedge pclk);
    pin_req <= 1'b0;
    wait_hi(0, n);
    in_range(n, REL, REL + 4);
    // Low supply: disabled, too short, then long enough.
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, CFG, {31'h0, k != 0});
      @(posedge pclk);
      low_req <= 1'b1;
      repeat (k == 1 ? 2900 : 3100) @(negedge pclk);
      check({31'h0, cpu_run}, {31'h0, k != 2});
      check(flags(), 32'h3);
      @(posedge pclk);
      low_req <= 1'b0;
      wait_hi(0, n);
    end
    // Power-on together with the pin wins and clears the flags.
    @(posedge pclk);
    por_req <= 1'b1;
    pin_req <= 1'b1;
    repeat (3) @(negedge pclk);
    check(flags(), 32'h0);
    check({27'h0, por_actions}, 32'h1F);
    @(posedge pclk);
    por_req <= 1'b0;
    pin_req <= 1'b0;
    wait_hi(0, n);
    close_out();
  end
endmodule : tb_reset_source_sequencer

/* verilog/low_supply_qualifier.sv */
// Filters the supply monitor's low indication by duration.
// Assumes the indication is synchronous to pclk.
`timescale 1ns/10ps
module low_supply_qualifier (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Supply monitor indication and filtered result.
  input wire logic low_supply,
  output logic qualified
);

  // Whole state of the filter.
  typedef struct packed {
    logic [11:0] count;
    logic qual;
  } qual_st_t;

  qual_st_t st;
  qual_st_t next_st;

  // duration filter
  // Counts consecutive low cycles; a gap restarts the count.
  always_comb begin
    next_st = st;
    if (!low_supply) begin
      next_st.count = 12'h000;
      next_st.qual = 1'b0;
    end else if (st.count != reset_seq_pkg::QUALIFY_CYCLES) begin
      next_st.count = st.count + 12'h001;
    end else begin
      next_st.qual = 1'b1;
    end
  end

  // Registers the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign qualified = st.qual;

  // Qualification only after a full run of low cycles.
  property p_qualify_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(qualified) |-> $past(st.count) == reset_seq_pkg::QUALIFY_CYCLES;
  endproperty
  a_qualify_len: assert property (p_qualify_len)
    else $error("low supply qualified too early");

endmodule : low_supply_qualifier

/* verilog/reset_seq_pkg.sv */
// Constants shared by the reset source sequencer and its supply filter.
// Assumes a single 50 MHz clock and an APB register port.
package reset_seq_pkg;

  // Clock rate in hertz and megahertz.
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CLK_MHZ = 50;

  // Delay after a reset source lets go, in milliseconds, and in cycles.
  localparam int unsigned RESET_RELEASE_DELAY_MS = 100;
  localparam int unsigned RELEASE_CYCLES =
    RESET_RELEASE_DELAY_MS * (CLK_HZ / 1000);

  // Least low-supply time that qualifies a reset, in ns, rounded up.
  localparam int unsigned LOW_SUPPLY_QUALIFY_NS = 60000;
  localparam logic [11:0] QUALIFY_CYCLES =
    12'((LOW_SUPPLY_QUALIFY_NS * CLK_MHZ + 999) / 1000);

  // Start-up timer lengths in oscillator cycles.
  localparam logic [22:0] STARTUP_LONG = 23'h000080;
  localparam logic [22:0] STARTUP_SHORT = 23'h000002;

  // Register byte offsets.
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;

  // Config register fields.
  localparam int CFG_LOWV_EN = 0;
  localparam int CFG_THRESH_LSB = 1;
  localparam int CFG_RC_OSC = 4;
  localparam int CFG_START_SHORT = 5;
  localparam logic [5:0] CONFIG_RESET = 6'h00;

  // Reset values loaded into the core registers.
  localparam logic [7:0] SECOND_CONTROL_RESET = 8'h8A;
  localparam logic [7:0] TIMER0_CONTROL_RESET = 8'h08;
  localparam logic [7:0] CONVERTER_CONTROL_RESET = 8'h40;

  // Power-on side actions, one bit each.
  localparam int ACT_IRQ_DISABLE = 0;
  localparam int ACT_WDOG_CLEAR = 1;
  localparam int ACT_TIMER_STOP = 2;
  localparam int ACT_PORTS_INPUT = 3;
  localparam int ACT_STACK_TOP = 4;
  localparam logic [4:0] ACT_ALL = 5'h1F;
  localparam logic [4:0] ACT_NONE = 5'h00;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HOLD = 4'h2,
    ST_DELAY = 4'h4,
    ST_START = 4'h8
  } seq_state_t;

  // Cause of the last reset.
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_POWER = 3'h1;
  localparam logic [2:0] CAUSE_PIN = 3'h2;
  localparam logic [2:0] CAUSE_LOWV = 3'h3;
  localparam logic [2:0] CAUSE_WDOG = 3'h4;
  localparam logic [2:0] CAUSE_WAKE = 3'h5;

endpackage : reset_seq_pkg

/* verilog/reset_source_sequencer.sv */
// Reset source sequencer: power-on, pin, low-supply and watchdog resets.
// Assumes all inputs are synchronous to pclk; presetn is the power-on
// reset; registers are reached over APB with 32-bit data.
// Operation
// - Low-supply reset only when configured on.
// - Low supply must last beyond qualifying time.
// - Threshold level selected by configuration code.
// - Hold execution for release delay afterwards.
// - Running watchdog reset acts like pin reset.
// - Sleeping watchdog clears PC, SP, wakes.
// - Start-up timer 128 or 2 cycles.
// - Power-on clears flags; running watchdog sets time-out flag, sleeping watchdog sets both.
// - Pin or low-supply reset keeps flags.
// - Power-on disables all interrupts.
// - Power-on clears and restarts watchdog.
// - Power-on stops timers, clears prescaler.
// - Power-on makes all ports inputs.
// - Power-on points stack at top.
// - Every reset zeroes program counter low byte.
// - Full resets load fixed control defaults.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module reset_source_sequencer #(
  parameter int unsigned RELEASE_CYCLES = reset_seq_pkg::RELEASE_CYCLES
) (
  // Clock and power-on reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources.
  input wire logic supply_por,
  input wire logic ext_reset_pin_n,
  input wire logic low_supply,
  input wire logic wdt_timeout,
  input wire logic sleeping,
  // Supply monitor threshold code.
  output logic [2:0] low_supply_threshold,
  // Core control.
  output logic cpu_run,
  output logic pc_clear,
  output logic sp_clear,
  output logic wake,
  output logic [4:0] por_actions,
  output logic timeout_flag,
  output logic powerdown_flag,
  // Register defaults held for the core.
  output logic [7:0] second_control_reg,
  output logic [7:0] timer0_control,
  output logic [7:0] converter_control
);

  // Whole state of the sequencer.
  typedef struct packed {
    reset_seq_pkg::seq_state_t state;
    logic [22:0] count;
    logic [2:0] cause;
    logic to_flag;
    logic pd_flag;
    logic [5:0] cfg;
    logic [7:0] ctl2;
    logic [7:0] tmr0;
    logic [7:0] conv;
    logic run;
    logic pcc;
    logic spc;
    logic wk;
    logic [4:0] acts;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } seq_st_t;

  seq_st_t st;
  seq_st_t next_st;
  logic qualified;
  logic src_low;
  logic wd_run;
  logic wd_sleep;
  logic [22:0] start_len;

  // Matches an APB address against a register offset.
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // Duration filter for the low-supply indication.
  low_supply_qualifier u_qual (
    .pclk(pclk),
    .presetn(presetn),
    .low_supply(low_supply),
    .qualified(qualified)
  );

  // Source decode; watchdog only counts while the core runs.
  always_comb begin
    src_low = st.cfg[reset_seq_pkg::CFG_LOWV_EN] & qualified;
    wd_run = wdt_timeout & (st.state == reset_seq_pkg::ST_RUN) & !sleeping;
    wd_sleep = wdt_timeout & (st.state == reset_seq_pkg::ST_RUN) & sleeping;
    if (st.cfg[reset_seq_pkg::CFG_RC_OSC] &&
        st.cfg[reset_seq_pkg::CFG_START_SHORT]) begin
      start_len = reset_seq_pkg::STARTUP_SHORT;
    end else begin
      start_len = reset_seq_pkg::STARTUP_LONG;
    end
  end

  // Next-state logic: bus access first, reset sources override it.
  always_comb begin
    next_st = st;
    next_st.pcc = 1'b0;
    next_st.spc = 1'b0;
    next_st.wk = 1'b0;
    // Zero-wait APB: pready rises in the access cycle.
    next_st.rdy = psel & !penable;
    next_st.err = psel & !penable &
      !(addr_hit(paddr, reset_seq_pkg::ADDR_CONFIG) ||
        addr_hit(paddr, reset_seq_pkg::ADDR_STATUS) ||
        addr_hit(paddr, reset_seq_pkg::ADDR_CTRL));
    // Read data is captured in the setup cycle.
    if (psel && !penable) begin
      if (addr_hit(paddr, reset_seq_pkg::ADDR_CONFIG)) begin
        next_st.rdata = {26'h0000000, st.cfg};
      end else if (addr_hit(paddr, reset_seq_pkg::ADDR_STATUS)) begin
        next_st.rdata = {22'h000000, st.run, st.cause, st.pd_flag,
                         st.to_flag, st.state};
      end else if (addr_hit(paddr, reset_seq_pkg::ADDR_CTRL)) begin
        next_st.rdata = {8'h00, st.conv, st.tmr0, st.ctl2};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
    // Writes take effect at the completing access edge.
    if (psel && penable && pwrite && st.rdy) begin
      if (addr_hit(paddr, reset_seq_pkg::ADDR_CONFIG)) begin
        next_st.cfg = pwdata[5:0];
      end else if (addr_hit(paddr, reset_seq_pkg::ADDR_CTRL)) begin
        next_st.ctl2 = pwdata[7:0];
        next_st.tmr0 = pwdata[15:8];
        next_st.conv = pwdata[23:16];
      end
    end
    if (supply_por) begin
      next_st.state = reset_seq_pkg::ST_HOLD;
      next_st.count = 23'h000000;
      next_st.cause = reset_seq_pkg::CAUSE_POWER;
      next_st.to_flag = 1'b0;
      next_st.pd_flag = 1'b0;
      next_st.acts = reset_seq_pkg::ACT_ALL;
    end else if (!ext_reset_pin_n || src_low) begin
      next_st.state = reset_seq_pkg::ST_HOLD;
      next_st.count = 23'h000000;
      next_st.cause = src_low ? reset_seq_pkg::CAUSE_LOWV
                              : reset_seq_pkg::CAUSE_PIN;
    end else if (wd_run) begin
      next_st.state = reset_seq_pkg::ST_DELAY;
      next_st.count = 23'h000000;
      next_st.cause = reset_seq_pkg::CAUSE_WDOG;
      next_st.to_flag = 1'b1;
    end else if (wd_sleep) begin
      next_st.state = reset_seq_pkg::ST_START;
      next_st.count = 23'h000000;
      next_st.cause = reset_seq_pkg::CAUSE_WAKE;
      next_st.to_flag = 1'b1;
      next_st.pd_flag = 1'b1;
      next_st.spc = 1'b1;
    end else begin
      case (st.state)
        // Source has let go: begin the release delay.
        reset_seq_pkg::ST_HOLD: begin
          next_st.state = reset_seq_pkg::ST_DELAY;
          next_st.count = 23'h000000;
        end
        reset_seq_pkg::ST_DELAY: begin
          if (st.count == 23'(RELEASE_CYCLES - 1)) begin
            next_st.state = reset_seq_pkg::ST_RUN;
            next_st.acts = reset_seq_pkg::ACT_NONE;
          end else begin
            next_st.count = st.count + 23'h000001;
          end
        end
        reset_seq_pkg::ST_START: begin
          if (st.count == start_len - 23'h000001) begin
            next_st.state = reset_seq_pkg::ST_RUN;
            next_st.wk = 1'b1;
          end else begin
            next_st.count = st.count + 23'h000001;
          end
        end
        // Running: nothing to do.
        reset_seq_pkg::ST_RUN: begin
          next_st.state = reset_seq_pkg::ST_RUN;
        end
        default: begin
          next_st.state = reset_seq_pkg::ST_HOLD;
        end
      endcase
    end
    if (supply_por || !ext_reset_pin_n || src_low || wd_run || wd_sleep) begin
      next_st.pcc = 1'b1;
    end
    if (supply_por || !ext_reset_pin_n || src_low || wd_run) begin
      next_st.ctl2 = reset_seq_pkg::SECOND_CONTROL_RESET;
      next_st.tmr0 = reset_seq_pkg::TIMER0_CONTROL_RESET;
      next_st.conv = reset_seq_pkg::CONVERTER_CONTROL_RESET;
    end
    next_st.run = (next_st.state == reset_seq_pkg::ST_RUN);
  end

  // Registers the state; reset is the power-on case.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{state: reset_seq_pkg::ST_HOLD, count: 23'h000000,
              cause: reset_seq_pkg::CAUSE_POWER, to_flag: 1'b0,
              pd_flag: 1'b0, cfg: reset_seq_pkg::CONFIG_RESET,
              ctl2: reset_seq_pkg::SECOND_CONTROL_RESET,
              tmr0: reset_seq_pkg::TIMER0_CONTROL_RESET,
              conv: reset_seq_pkg::CONVERTER_CONTROL_RESET,
              run: 1'b0, pcc: 1'b1, spc: 1'b0, wk: 1'b0,
              acts: reset_seq_pkg::ACT_ALL, rdata: 32'h00000000,
              rdy: 1'b0, err: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flip-flops.
  assign prdata = st.rdata;
  assign pready = st.rdy;
  assign pslverr = st.err;
  assign low_supply_threshold = st.cfg[reset_seq_pkg::CFG_THRESH_LSB +: 3];
  assign cpu_run = st.run;
  assign pc_clear = st.pcc;
  assign sp_clear = st.spc;
  assign wake = st.wk;
  assign por_actions = st.acts;
  assign timeout_flag = st.to_flag;
  assign powerdown_flag = st.pd_flag;
  assign second_control_reg = st.ctl2;
  assign timer0_control = st.tmr0;
  assign converter_control = st.conv;

  // Checks on the sequencer.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lowv_gate;
    (!st.cfg[reset_seq_pkg::CFG_LOWV_EN] && !supply_por && ext_reset_pin_n
     && st.state == reset_seq_pkg::ST_RUN && !wdt_timeout) |=> cpu_run;
  endproperty
  a_lowv_gate: assert property (p_lowv_gate)
    else $error("disabled low-supply source caused a reset");

  // A completed configuration write reaches the monitor next cycle.
  property p_thresh;
    psel && penable && pwrite && pready &&
      paddr == reset_seq_pkg::ADDR_CONFIG |=> low_supply_threshold ==
      $past(pwdata[reset_seq_pkg::CFG_THRESH_LSB +: 3]);
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("threshold code does not follow configuration");
  property p_release;
    $rose(cpu_run) && $past(st.state) == reset_seq_pkg::ST_DELAY |->
      $past(st.count) == 23'(RELEASE_CYCLES - 1);
  endproperty
  a_release: assert property (p_release)
    else $error("execution released before the delay ran out");
  property p_wdog_run;
    wd_run && !supply_por && ext_reset_pin_n && !src_low |=>
      timeout_flag && !cpu_run && second_control_reg ==
      reset_seq_pkg::SECOND_CONTROL_RESET;
  endproperty
  a_wdog_run: assert property (p_wdog_run)
    else $error("running watchdog reset handled wrongly");
  property p_wdog_sleep;
    wd_sleep && !supply_por && ext_reset_pin_n && !src_low |=>
      timeout_flag && powerdown_flag && sp_clear && pc_clear &&
      $stable(second_control_reg) && $stable(converter_control);
  endproperty
  a_wdog_sleep: assert property (p_wdog_sleep)
    else $error("sleeping watchdog wake handled wrongly");
  property p_start_len;
    $rose(wake) |-> $past(st.count) == start_len - 23'h000001;
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("start-up timer length wrong");
  property p_power_flags;
    supply_por |=> !timeout_flag && !powerdown_flag &&
      por_actions == reset_seq_pkg::ACT_ALL &&
      st.cause == reset_seq_pkg::CAUSE_POWER;
  endproperty
  a_power_flags: assert property (p_power_flags)
    else $error("power-on did not dominate or clear flags");
  property p_pin_flags;
    !supply_por && (!ext_reset_pin_n || src_low) |=>
      $stable(timeout_flag) && $stable(powerdown_flag);
  endproperty
  a_pin_flags: assert property (p_pin_flags)
    else $error("pin or low-supply reset changed flags");

  property p_por_acts;
    por_actions == reset_seq_pkg::ACT_ALL |-> !cpu_run;
  endproperty
  a_por_acts: assert property (p_por_acts)
    else $error("power-on actions held while running");

  property p_pc_zero;
    !ext_reset_pin_n |=> pc_clear && !cpu_run;
  endproperty
  a_pc_zero: assert property (p_pc_zero)
    else $error("pin reset did not clear the program counter");

  c_wake: cover property ($rose(wake));
  c_pin_run: cover property ($fell(ext_reset_pin_n) ##[1:100] $rose(cpu_run));
  c_lowv: cover property (st.cause == reset_seq_pkg::CAUSE_LOWV && cpu_run);
  c_wdog: cover property (wd_run);

endmodule : reset_source_sequencer
